//--- logic/eqc_device.sv
// device end: control registers and indirect coefficient access port
`timescale 1ns/1ns
`default_nettype none
`include "eqc_consts.svh"
module eqc_device #(
    parameter int DEPTH = `EQC_DEPTH,
    parameter int WIDTH = `EQC_WIDTH
) (
    // register link
    eqc_link_if.device                link,
    // input configuration
    input  wire logic                 sixChannel,
    // processing side
    input  wire logic [2:0]           dspChan,
    input  wire logic [1:0]           dspStage,
    input  wire logic [2:0]           dspTerm,
    output logic      [WIDTH-1:0]     dspCoef,
    output eqc_pkg::eqc_group_t       dspGroup,
    output logic                      staticEqOn,
    output logic                      sideFireOn,
    output logic      [5:0]           redirChanEn,
    output logic                      accessBusy
);
    import eqc_pkg::*;

    logic [15:0]           eqsf_q;
    logic [15:0]           bass_q;
    logic [15:0]           data_q;
    logic [7:0]            loc_q;
    logic                  rdSel_q;
    logic [3:0]            nib_q;
    logic                  go_q;
    logic                  ack_q;
    logic [15:0]           rdata_q;
    logic                  take;
    logic                  wrWord;
    logic                  wrByte;
    logic [7:0]            idxRaw;
    logic                  idxOk;
    logic [WIDTH-1:0]      ramRd;
    logic [`EQC_IDX_W-1:0] dspIdx;

    // one request per ack cycle; host still holds req while ack is up, so that cycle is ignored
    assign take   = link.req && !ack_q;
    assign wrWord = take && link.we && link.wide;
    assign wrByte = take && link.we && !link.wide;

    assign link.ack   = ack_q;
    assign link.rdata = rdata_q;

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // control registers, whole word or one byte of it
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            eqsf_q <= 16'h0000;
            bass_q <= 16'h0000;
        end else if (wrWord) begin
            if (link.addr == `EQC_REG_EQSF) eqsf_q <= link.wdata;
            if (link.addr == `EQC_REG_BASS) bass_q <= link.wdata;
        end else if (wrByte) begin
            if (link.addr == `EQC_REG_EQSF) eqsf_q[15:8] <= link.wdata[7:0];
            if (link.addr == `EQC_REG_EQSF + 8'h01) eqsf_q[7:0] <= link.wdata[7:0];
            if (link.addr == `EQC_REG_BASS) bass_q[15:8] <= link.wdata[7:0];
            if (link.addr == `EQC_REG_BASS + 8'h01) bass_q[7:0] <= link.wdata[7:0];
        end
    end

    // data register: host writes it, a finished read overwrites it
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            data_q <= 16'h0000;
        end else if (go_q && rdSel_q && idxOk) begin
            data_q <= ramRd[15:0];
        end else if (wrWord && link.addr == `EQC_REG_DATA) begin
            data_q <= link.wdata;
        end else if (wrByte && link.addr == `EQC_REG_DATA) begin
            data_q[15:8] <= link.wdata[7:0];
        end else if (wrByte && link.addr == `EQC_REG_DATA_LO) begin
            data_q[7:0] <= link.wdata[7:0];
        end
    end

    // address/control register
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            loc_q   <= 8'h00;
            rdSel_q <= 1'b0;
            nib_q   <= 4'h0;
        end else if (go_q && rdSel_q && idxOk) begin
            nib_q <= ramRd[WIDTH-1:16];
        end else if (wrWord && link.addr == `EQC_REG_ACTL) begin
            loc_q   <= link.wdata[15:8];
            rdSel_q <= link.wdata[`EQC_RW_BIT];
            nib_q   <= link.wdata[3:0];
        end else if (wrByte && link.addr == `EQC_REG_ACTL) begin
            loc_q <= link.wdata[7:0];
        end else if (wrByte && link.addr == `EQC_REG_ACTL_LO) begin
            rdSel_q <= link.wdata[`EQC_RW_BIT];
            nib_q   <= link.wdata[3:0];
        end
    end

    // the access fires only on the word at 7Ah or the byte at 7Bh;
    // the byte at 7Ah only stages the location
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            go_q <= 1'b0;
        end else begin
            go_q <= (wrWord && link.addr == `EQC_REG_ACTL) ||
                    (wrByte && link.addr == `EQC_REG_ACTL_LO);
        end
    end

    assign accessBusy = go_q;

    // locations outside the table are dropped silently
    assign idxRaw = loc_q - `EQC_LOC_BASE;
    assign idxOk  = (loc_q >= `EQC_LOC_BASE) && (idxRaw < 8'(DEPTH));

    eqc_coef_ram #(
        .DEPTH (DEPTH),
        .WIDTH (WIDTH)
    ) uRam (
        .clk     (link.clk),
        .rstn    (link.rstn),
        .wrEn    (go_q && !rdSel_q && idxOk),
        .wrIdx   (idxRaw[`EQC_IDX_W-1:0]),
        .wrData  ({nib_q, data_q}),
        .rdIdx   (idxRaw[`EQC_IDX_W-1:0]),
        .rdData  (ramRd),
        .dspIdx  (dspIdx),
        .dspData (dspCoef)
    );

    // register read mux; a read in progress shows the held values
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            rdata_q <= 16'h0000;
        end else if (take && !link.we) begin
            rdata_q <= 16'h0000;
            if (link.wide) begin
                unique case (link.addr)
                    `EQC_REG_EQSF: rdata_q <= eqsf_q;
                    `EQC_REG_BASS: rdata_q <= bass_q;
                    `EQC_REG_DATA: rdata_q <= data_q;
                    `EQC_REG_ACTL: rdata_q <= {loc_q, 3'b000, rdSel_q, nib_q};
                    default:       rdata_q <= 16'h0000;
                endcase
            end else begin
                unique case (link.addr)
                    `EQC_REG_EQSF:          rdata_q <= {8'h00, eqsf_q[15:8]};
                    `EQC_REG_EQSF + 8'h01:  rdata_q <= {8'h00, eqsf_q[7:0]};
                    `EQC_REG_BASS:          rdata_q <= {8'h00, bass_q[15:8]};
                    `EQC_REG_BASS + 8'h01:  rdata_q <= {8'h00, bass_q[7:0]};
                    `EQC_REG_DATA:          rdata_q <= {8'h00, data_q[15:8]};
                    `EQC_REG_DATA_LO:       rdata_q <= {8'h00, data_q[7:0]};
                    `EQC_REG_ACTL:          rdata_q <= {8'h00, loc_q};
                    `EQC_REG_ACTL_LO:       rdata_q <= {8'h00, 3'b000, rdSel_q, nib_q};
                    default:                rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // processing side view of the enables
    assign staticEqOn = eqsf_q[`EQC_EQ_EN_BIT];
    assign sideFireOn = eqsf_q[`EQC_SF_EN_BIT];

    // channels: 0 L, 1 R, 2 LS, 3 RS, 4 C, 5 LFE
    assign redirChanEn = bass_q[`EQC_BR_EN_BIT] ?
                         {sixChannel, sixChannel, 4'hF} : 6'h00;

    // left/right share one set, the surrounds another, C and LFE the sub set
    always_comb begin
        unique case (dspChan)
            3'h0, 3'h1: dspGroup = EQC_G_FRONT;
            3'h2, 3'h3: dspGroup = EQC_G_SURR;
            default:    dspGroup = EQC_G_SUB;
        endcase
    end

    // index = group*20 + stage*5 + term; term order b2, b0-1, a2, a1/2, b1/2
    assign dspIdx = 7'(dspGroup) * `EQC_GROUP_SIZE
                  + 7'(dspStage) * `EQC_STAGE_TERMS
                  + 7'(dspTerm);
endmodule // eqc_device
`default_nettype wire

//--- common/eqc_consts.svh
// constants of the coefficient access port: offsets, fields, defaults
`ifndef EQC_CONSTS_SVH
`define EQC_CONSTS_SVH

`define EQC_REG_EQSF      8'h70
`define EQC_REG_BASS      8'h72
`define EQC_REG_DATA      8'h78
`define EQC_REG_DATA_LO   8'h79
`define EQC_REG_ACTL      8'h7A
`define EQC_REG_ACTL_LO   8'h7B

`define EQC_LOC_BASE      8'h40
`define EQC_DEPTH         69
`define EQC_WIDTH         20
`define EQC_IDX_W         7

`define EQC_RW_BIT        4
`define EQC_EQ_EN_BIT     0
`define EQC_SF_EN_BIT     1
`define EQC_BR_EN_BIT     0

`define EQC_GROUP_SIZE    7'h14
`define EQC_STAGE_TERMS   7'h05

`define EQC_IDX_SBW0      7'h28
`define EQC_IDX_SCALE     7'h3C
`define EQC_IDX_REDIR     7'h3F
`define EQC_IDX_LFE       7'h44

`define EQC_DEF_ZERO      20'h00000
`define EQC_DEF_SBW00     20'h00032
`define EQC_DEF_SBW01     20'h80032
`define EQC_DEF_SBW02     20'h7C7EA
`define EQC_DEF_SBW03     20'h81C6F
`define EQC_DEF_SBW04     20'h00032
`define EQC_DEF_FULL      20'h80000
`define EQC_DEF_HALF      20'hC0000

`endif

//--- common/eqc_pkg.sv
// types shared by both ends of the coefficient access port
`default_nettype none
package eqc_pkg;
    typedef enum logic [1:0] {
        EQC_G_FRONT = 2'b00,
        EQC_G_SURR  = 2'b01,
        EQC_G_SUB   = 2'b10
    } eqc_group_t;

    typedef enum logic [1:0] {
        EQC_OP_WRCOEF = 2'b00,
        EQC_OP_RDCOEF = 2'b01,
        EQC_OP_WRREG  = 2'b10
    } eqc_op_t;

    typedef enum logic [1:0] {
        EQC_H_IDLE = 2'b00,
        EQC_H_REQ  = 2'b01,
        EQC_H_GAP  = 2'b10
    } eqc_hstate_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wide;
        logic       we;
        logic       last;
    } eqc_step_t;
endpackage
`default_nettype wire

//--- common/eqc_link_if.sv
// register link between host controller and the coefficient access port
`timescale 1ns/1ns
`default_nettype none
interface eqc_link_if (
    input wire logic clk,
    input wire logic rstn
);
    logic        req;
    logic        wide;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;

    modport device (input clk, rstn, req, wide, we, addr, wdata, output rdata, ack);
    modport host   (input clk, rstn, rdata, ack, output req, wide, we, addr, wdata);
endinterface // eqc_link_if
`default_nettype wire

//--- logic/eqc_coef_ram.sv
// coefficient memory: one flop word per entry, reset to its default
`timescale 1ns/1ns
`default_nettype none
`include "eqc_consts.svh"
module eqc_coef_ram #(
    parameter int DEPTH = `EQC_DEPTH,
    parameter int WIDTH = `EQC_WIDTH
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // host side port
    input  wire logic                  wrEn,
    input  wire logic [`EQC_IDX_W-1:0] wrIdx,
    input  wire logic [WIDTH-1:0]      wrData,
    input  wire logic [`EQC_IDX_W-1:0] rdIdx,
    output logic      [WIDTH-1:0]      rdData,
    // processing side read port
    input  wire logic [`EQC_IDX_W-1:0] dspIdx,
    output logic      [WIDTH-1:0]      dspData
);
    import eqc_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];

    function automatic logic [WIDTH-1:0] defVal(input logic [`EQC_IDX_W-1:0] i);
        logic [WIDTH-1:0] v;
        v = WIDTH'(`EQC_DEF_ZERO);
        if (i == `EQC_IDX_SBW0) v = WIDTH'(`EQC_DEF_SBW00);
        else if (i == `EQC_IDX_SBW0 + 7'h01) v = WIDTH'(`EQC_DEF_SBW01);
        else if (i == `EQC_IDX_SBW0 + 7'h02) v = WIDTH'(`EQC_DEF_SBW02);
        else if (i == `EQC_IDX_SBW0 + 7'h03) v = WIDTH'(`EQC_DEF_SBW03);
        else if (i == `EQC_IDX_SBW0 + 7'h04) v = WIDTH'(`EQC_DEF_SBW04);
        else if (i >= `EQC_IDX_SCALE && i < `EQC_IDX_REDIR) v = WIDTH'(`EQC_DEF_FULL);
        else if (i >= `EQC_IDX_REDIR && i < `EQC_IDX_LFE) v = WIDTH'(`EQC_DEF_HALF);
        else if (i == `EQC_IDX_LFE) v = WIDTH'(`EQC_DEF_FULL);
        return v;
    endfunction

    // flops rather than a macro so every entry powers up at its default
    for (genvar g = 0; g < DEPTH; g++) begin : gEntry
        localparam logic [`EQC_IDX_W-1:0] IDX = `EQC_IDX_W'(g);
        localparam logic [WIDTH-1:0] DEF = defVal(IDX);
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                mem[g] <= DEF;
            end else if (wrEn && wrIdx == IDX) begin
                mem[g] <= wrData;
            end
        end
    end

    assign rdData  = (rdIdx  < `EQC_IDX_W'(DEPTH)) ? mem[rdIdx]  : '0;
    assign dspData = (dspIdx < `EQC_IDX_W'(DEPTH)) ? mem[dspIdx] : '0;
endmodule // eqc_coef_ram
`default_nettype wire

//--- logic/eqc_host.sv
// host end: sequences coefficient and register accesses over the link
`timescale 1ns/1ns
`default_nettype none
`include "eqc_consts.svh"
module eqc_host (
    // register link
    eqc_link_if.host             link,
    // command port
    input  wire logic            useI2c,
    input  wire logic            cmdValid,
    output logic                 cmdReady,
    input  wire eqc_pkg::eqc_op_t cmdOp,
    input  wire logic [6:0]      cmdIndex,
    input  wire logic [7:0]      cmdAddr,
    input  wire logic [19:0]     cmdData,
    // result
    output logic                 doneValid,
    output logic      [19:0]     rdCoef
);
    import eqc_pkg::*;

    eqc_hstate_t state_q;
    eqc_op_t     op_q;
    logic        i2c_q;
    logic [2:0]  step_q;
    logic [7:0]  loc_q;
    logic [7:0]  regAddr_q;
    logic [19:0] data_q;
    logic [19:0] rdCoef_q;
    logic        done_q;
    eqc_step_t   st;
    logic        rdOp;

    assign rdOp = (op_q == EQC_OP_RDCOEF);

    // step table of each access sequence
    always_comb begin
        st = '{addr: 8'h00, wide: 1'b1, we: 1'b1, last: 1'b1};
        if (op_q == EQC_OP_WRREG) begin
            st = '{addr: regAddr_q, wide: 1'b1, we: 1'b1, last: 1'b1};
        end else if (!i2c_q && !rdOp) begin
            unique case (step_q)
                3'd0:    st = '{addr: `EQC_REG_DATA, wide: 1'b1, we: 1'b1, last: 1'b0};
                default: st = '{addr: `EQC_REG_ACTL, wide: 1'b1, we: 1'b1, last: 1'b1};
            endcase
        end else if (!i2c_q) begin
            unique case (step_q)
                3'd0:    st = '{addr: `EQC_REG_ACTL, wide: 1'b1, we: 1'b1, last: 1'b0};
                3'd1:    st = '{addr: `EQC_REG_DATA, wide: 1'b1, we: 1'b0, last: 1'b0};
                default: st = '{addr: `EQC_REG_ACTL, wide: 1'b1, we: 1'b0, last: 1'b1};
            endcase
        end else if (!rdOp) begin
            unique case (step_q)
                3'd0:    st = '{addr: `EQC_REG_DATA,    wide: 1'b0, we: 1'b1, last: 1'b0};
                3'd1:    st = '{addr: `EQC_REG_DATA_LO, wide: 1'b0, we: 1'b1, last: 1'b0};
                3'd2:    st = '{addr: `EQC_REG_ACTL,    wide: 1'b0, we: 1'b1, last: 1'b0};
                default: st = '{addr: `EQC_REG_ACTL_LO, wide: 1'b0, we: 1'b1, last: 1'b1};
            endcase
        end else begin
            unique case (step_q)
                3'd0:    st = '{addr: `EQC_REG_ACTL,    wide: 1'b0, we: 1'b1, last: 1'b0};
                3'd1:    st = '{addr: `EQC_REG_ACTL_LO, wide: 1'b0, we: 1'b1, last: 1'b0};
                3'd2:    st = '{addr: `EQC_REG_DATA,    wide: 1'b0, we: 1'b0, last: 1'b0};
                3'd3:    st = '{addr: `EQC_REG_DATA_LO, wide: 1'b0, we: 1'b0, last: 1'b0};
                default: st = '{addr: `EQC_REG_ACTL_LO, wide: 1'b0, we: 1'b0, last: 1'b1};
            endcase
        end
    end

    // outgoing data per target
    always_comb begin
        link.wdata = 16'h0000;
        if (op_q == EQC_OP_WRREG) begin
            link.wdata = data_q[15:0];
        end else if (st.addr == `EQC_REG_DATA) begin
            link.wdata = st.wide ? data_q[15:0] : {8'h00, data_q[15:8]};
        end else if (st.addr == `EQC_REG_DATA_LO) begin
            link.wdata = {8'h00, data_q[7:0]};
        end else if (st.addr == `EQC_REG_ACTL) begin
            link.wdata = st.wide ? {loc_q, 3'b000, rdOp, data_q[19:16]}
                                 : {8'h00, loc_q};
        end else if (st.addr == `EQC_REG_ACTL_LO) begin
            link.wdata = {8'h00, 3'b000, rdOp, data_q[19:16]};
        end
    end

    assign link.req  = (state_q == EQC_H_REQ);
    assign link.addr = st.addr;
    assign link.wide = st.wide;
    assign link.we   = st.we;
    assign cmdReady  = (state_q == EQC_H_IDLE);
    assign doneValid = done_q;
    assign rdCoef    = rdCoef_q;

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            state_q   <= EQC_H_IDLE;
            op_q      <= EQC_OP_WRCOEF;
            i2c_q     <= 1'b0;
            step_q    <= 3'd0;
            loc_q     <= 8'h00;
            regAddr_q <= 8'h00;
            data_q    <= 20'h00000;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                EQC_H_IDLE: begin
                    if (cmdValid) begin
                        state_q   <= EQC_H_REQ;
                        op_q      <= cmdOp;
                        i2c_q     <= useI2c;
                        step_q    <= 3'd0;
                        loc_q     <= {1'b0, cmdIndex} + `EQC_LOC_BASE;
                        regAddr_q <= cmdAddr;
                        data_q    <= cmdData;
                    end
                end
                EQC_H_REQ: begin
                    if (link.ack) begin
                        state_q <= EQC_H_GAP;
                    end
                end
                EQC_H_GAP: begin
                    // one idle cycle lets the started access land first
                    if (st.last) begin
                        state_q <= EQC_H_IDLE;
                        done_q  <= 1'b1;
                    end else begin
                        state_q <= EQC_H_REQ;
                        step_q  <= step_q + 3'd1;
                    end
                end
                default: state_q <= EQC_H_IDLE;
            endcase
        end
    end

    // gather the read pieces back into one coefficient
    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            rdCoef_q <= 20'h00000;
        end else if (state_q == EQC_H_REQ && link.ack && !st.we) begin
            if (st.addr == `EQC_REG_DATA && st.wide) rdCoef_q[15:0] <= link.rdata;
            if (st.addr == `EQC_REG_DATA && !st.wide) rdCoef_q[15:8] <= link.rdata[7:0];
            if (st.addr == `EQC_REG_DATA_LO) rdCoef_q[7:0] <= link.rdata[7:0];
            if (st.addr == `EQC_REG_ACTL || st.addr == `EQC_REG_ACTL_LO) begin
                rdCoef_q[19:16] <= link.rdata[3:0];
            end
        end
    end
endmodule // eqc_host
`default_nettype wire

//--- tb/eqc_link_sva.sv
// link protocol checker for the coefficient access port
`timescale 1ns/1ns
`default_nettype none
module eqc_link_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // link signals
    input wire logic        req,
    input wire logic        wide,
    input wire logic        we,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack
);
    logic [7:0] locQ;
    logic       selQ;
    logic       take;
    logic       startWr;

    assign take    = req && !ack;
    assign startWr = we && (wide ? addr == 8'h7A : addr == 8'h7B);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // shadow of location and select, so read-back can be judged
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locQ <= 8'h00;
            selQ <= 1'b0;
        end else if (take && we) begin
            if (wide && addr == 8'h7A) begin
                locQ <= wdata[15:8];
                selQ <= wdata[4];
            end
            if (!wide && addr == 8'h7A) locQ <= wdata[7:0];
            if (!wide && addr == 8'h7B) selQ <= wdata[4];
        end
    end

    ack_follow_a: assert property (take |=> ack)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
        else $error("answer without request");
    start_gap_a: assert property (ack && $past(startWr) |=> !req)
        else $error("no idle cycle after access start");
    byte_pad_a: assert property (ack && $past(!we && !wide) |-> rdata[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    loc_echo_a: assert property (
        ack && $past(!we && wide && addr == 8'h7A) |-> rdata[15:8] == locQ)
        else $error("location byte not kept");
    sel_word_a: assert property (
        ack && $past(!we && wide && addr == 8'h7A) |-> rdata[7:4] == {3'b000, selQ})
        else $error("word select field wrong");
    sel_byte_a: assert property (
        ack && $past(!we && !wide && addr == 8'h7B) |-> rdata[7:4] == {3'b000, selQ})
        else $error("byte select field wrong");

    cover property (ack && $past(startWr && wide));
    cover property (ack && $past(startWr && !wide));
    cover property (ack && $past(!we && !wide && addr == 8'h7B));
endmodule // eqc_link_sva
`default_nettype wire

//--- tb/eq_coefficient_access_test.sv
// both ends joined over the link, driven from the host command port
`timescale 1ns/1ns
`default_nettype none
module eq_coefficient_access_test;
    import eqc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, useI2c = 1'b0, cmdValid = 1'b0, sixChannel = 1'b0;
    eqc_op_t     cmdOp = EQC_OP_RDCOEF;
    logic [6:0]  cmdIndex = 7'h00;
    logic [7:0]  cmdAddr = 8'h00;
    logic [19:0] cmdData = 20'h00000, rdCoef, dspCoef;
    logic [2:0]  dspChan = 3'h0, dspTerm = 3'h0;
    logic [1:0]  dspStage = 2'h0;
    logic        cmdReady, doneValid, staticEqOn, sideFireOn, accessBusy;
    logic [5:0]  redirChanEn;
    eqc_group_t  dspGroup;
    int          nErrors = 0, nCompared = 0, nBusy = 0;

    always #25 clk = ~clk;

    // busy stands a whole cycle, so the falling edge sees each start once
    always @(negedge clk) if (accessBusy === 1'b1) nBusy++;

    eqc_link_if eqc_link_if_inst (.clk(clk), .rstn(rstn));
    eqc_host eqc_host_inst (.link(eqc_link_if_inst), .useI2c(useI2c), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdIndex(cmdIndex), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .doneValid(doneValid), .rdCoef(rdCoef));
    eqc_device eqc_device_inst (.link(eqc_link_if_inst), .sixChannel(sixChannel),
        .dspChan(dspChan), .dspStage(dspStage), .dspTerm(dspTerm), .dspCoef(dspCoef),
        .dspGroup(dspGroup), .staticEqOn(staticEqOn), .sideFireOn(sideFireOn),
        .redirChanEn(redirChanEn), .accessBusy(accessBusy));
    eqc_link_sva eqc_link_sva_inst (.clk(clk), .rstn(rstn), .req(eqc_link_if_inst.req),
        .wide(eqc_link_if_inst.wide), .we(eqc_link_if_inst.we), .addr(eqc_link_if_inst.addr),
        .wdata(eqc_link_if_inst.wdata), .rdata(eqc_link_if_inst.rdata),
        .ack(eqc_link_if_inst.ack));

    task automatic stopTest;
        $display("compared %0d, mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one host command, waits for its completion pulse under a bound
    task automatic cmd(input eqc_op_t op, input logic [6:0] ix, input logic [19:0] d,
                       input logic [7:0] a, input logic i2c);
        int n;
        n = 0;
        @(negedge clk);
        cmdOp = op;
        cmdIndex = ix;
        cmdData = d;
        cmdAddr = a;
        useI2c = i2c;
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        @(negedge clk);
        cmdValid = 1'b0;
        while (doneValid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        if (n >= 100) begin
            nErrors++;
            $display("CHECK FAILED at %0t: command timed out", $time);
            stopTest();
        end
    endtask

    task automatic probe(input logic [2:0] c, input logic [1:0] s, input logic [2:0] t,
                         input logic [19:0] e, input eqc_group_t g);
        @(negedge clk);
        {dspChan, dspStage, dspTerm} = {c, s, t};
        #1;
        chk(dspCoef, e);
        chk({18'h0, dspGroup}, {18'h0, g});
    endtask

    task automatic test_defaults;
        logic [6:0]  ix [5] = '{7'h28, 7'h2B, 7'h3C, 7'h3F, 7'h44};
        logic [19:0] ex [5] = '{20'h00032, 20'h81C6F, 20'h80000, 20'hC0000, 20'h80000};
        int          n0;
        n0 = nBusy;
        for (int v = 0; v < 2; v++) begin
            for (int i = 0; i < 5; i++) begin
                cmd(EQC_OP_RDCOEF, ix[i], 20'h00000, 8'h00, v[0]);
                chk(rdCoef, ex[i]);
            end
        end
        // every coefficient read starts exactly one access
        chk(20'(nBusy - n0), 20'h0000A);
        $display("test defaults done");
    endtask

    task automatic test_write;
        logic [6:0]  wi [3] = '{7'h00, 7'h22, 7'h44};
        logic [19:0] wd [3] = '{20'hA5C3E, 20'h5F0A1, 20'h12345};
        for (int i = 0; i < 3; i++) begin
            cmd(EQC_OP_WRCOEF, wi[i], wd[i], 8'h00, !i[0]);
            cmd(EQC_OP_RDCOEF, wi[i], 20'h00000, 8'h00, i[0]);
            chk(rdCoef, wd[i]);
        end
        probe(3'd1, 2'd0, 3'd0, 20'hA5C3E, EQC_G_FRONT);
        probe(3'd2, 2'd2, 3'd4, 20'h5F0A1, EQC_G_SURR);
        probe(3'd5, 2'd0, 3'd3, 20'h81C6F, EQC_G_SUB);
        $display("test write done");
    endtask

    task automatic test_controls;
        cmd(EQC_OP_WRREG, 7'h00, 20'h00003, 8'h70, 1'b0);
        chk({19'h0, staticEqOn}, 20'h00001);
        chk({19'h0, sideFireOn}, 20'h00001);
        cmd(EQC_OP_WRREG, 7'h00, 20'h00002, 8'h70, 1'b0);
        chk({19'h0, staticEqOn}, 20'h00000);
        chk({19'h0, sideFireOn}, 20'h00001);
        for (int s = 0; s < 2; s++) begin
            @(negedge clk) sixChannel = s[0];
            cmd(EQC_OP_WRREG, 7'h00, 20'h00001, 8'h72, 1'b0);
            chk({14'h0, redirChanEn}, s ? 20'h0003F : 20'h0000F);
            cmd(EQC_OP_WRREG, 7'h00, 20'h00000, 8'h72, 1'b0);
            chk({14'h0, redirChanEn}, 20'h00000);
        end
        // scale factors at the two ends of their legal range
        cmd(EQC_OP_WRCOEF, 7'h3F, 20'h80000, 8'h00, 1'b0);
        cmd(EQC_OP_RDCOEF, 7'h3F, 20'h00000, 8'h00, 1'b1);
        chk(rdCoef, 20'h80000);
        cmd(EQC_OP_WRCOEF, 7'h3C, 20'h00000, 8'h00, 1'b1);
        cmd(EQC_OP_RDCOEF, 7'h3C, 20'h00000, 8'h00, 1'b0);
        chk(rdCoef, 20'h00000);
        $display("test controls done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        test_defaults();
        test_write();
        test_controls();
        stopTest();
    end
endmodule // eq_coefficient_access_test
`default_nettype wire
